//--- rtl/peq_pkg.sv
// constants and helpers shared by the event qualifier
package peq_pkg;
  localparam int SEL_W = 6;
  localparam int NUM_PIPES = 2;
  localparam int PIPE_U = 0;
  localparam int PIPE_V = 1;
  localparam logic [SEL_W-1:0] EVT_SEG_LOAD = 6'h0f;
  localparam logic [SEL_W-1:0] EVT_RSVD_A = 6'h10;
  localparam logic [SEL_W-1:0] EVT_RSVD_B = 6'h11;
  localparam logic [SEL_W-1:0] EVT_BRANCH = 6'h12;
  localparam logic [SEL_W-1:0] EVT_TGT_HIT = 6'h13;
  localparam logic [SEL_W-1:0] EVT_BR_OR_HIT = 6'h14;
  localparam logic [SEL_W-1:0] EVT_FLUSH = 6'h15;
  localparam logic [SEL_W-1:0] EVT_INSN = 6'h16;
  localparam logic [SEL_W-1:0] EVT_INSN_V = 6'h17;
  localparam logic [SEL_W-1:0] EVT_BUS = 6'h18;
  localparam logic [SEL_W-1:0] EVT_STQ = 6'h19;
  // flush cause vector bit positions
  localparam int FL_W = 7;
  localparam int FL_BTB_MISS = 0;
  localparam int FL_MISPRED = 1;
  localparam int FL_EXCEPT = 2;
  localparam int FL_INTR = 3;
  localparam int FL_DESC = 4;
  localparam int FL_SERIAL = 5;
  localparam int FL_SW_INT = 6;
  localparam logic [FL_W-1:0] FL_COUNT_MASK = 7'h1f;
  localparam logic [1:0] INC_ZERO = 2'h0;
  localparam logic [1:0] INC_ONE = 2'h1;
  localparam logic [1:0] INC_TWO = 2'h2;
  localparam logic [1:0] INC_MAX = 2'h3;
  typedef enum logic [1:0] {
    PEQ_CLS_NONE,
    PEQ_CLS_OCCUR,
    PEQ_CLS_DURATION
  } peq_class_t;
  function automatic logic [1:0] peq_pop2(input logic [1:0] v);
    return {1'b0, v[0]} + {1'b0, v[1]};
  endfunction : peq_pop2
  function automatic logic [1:0] peq_sat_add(input logic [1:0] a, input logic b);
    logic [2:0] s;
    s = {1'b0, a} + {2'h0, b};
    return s[2] ? INC_MAX : s[1:0];
  endfunction : peq_sat_add
  function automatic peq_class_t peq_class(input logic [SEL_W-1:0] sel);
    case (sel)
      EVT_SEG_LOAD, EVT_BRANCH, EVT_TGT_HIT, EVT_BR_OR_HIT,
      EVT_FLUSH, EVT_INSN, EVT_INSN_V: return PEQ_CLS_OCCUR;
      EVT_BUS, EVT_STQ: return PEQ_CLS_DURATION;
      default: return PEQ_CLS_NONE;
    endcase
  endfunction : peq_class
endpackage : peq_pkg

//--- rtl/peq_pipe_if.sv
// per-pipe event sources and their qualified results
`timescale 1ns/1ps
`default_nettype none
interface peq_pipe_if;
  logic [peq_pkg::NUM_PIPES-1:0] exec;
  logic [peq_pkg::NUM_PIPES-1:0] rep_iter;
  logic [peq_pkg::NUM_PIPES-1:0] br_exec;
  logic [peq_pkg::NUM_PIPES-1:0] br_taken;
  logic [peq_pkg::NUM_PIPES-1:0] tgt_hit;
  logic [peq_pkg::NUM_PIPES-1:0] insn_q;
  logic [peq_pkg::NUM_PIPES-1:0] br_q;
  logic [peq_pkg::NUM_PIPES-1:0] or_q;
  logic [peq_pkg::NUM_PIPES-1:0] hit_q;
  modport src (
    output exec, rep_iter, br_exec, br_taken, tgt_hit,
    input insn_q, br_q, or_q, hit_q
  );
  modport qual (
    input exec, rep_iter, br_exec, br_taken, tgt_hit,
    output insn_q, br_q, or_q, hit_q
  );
endinterface : peq_pipe_if
`default_nettype wire

//--- rtl/peq_pipe_qualifier.sv
// qualifies per-pipe instruction, branch and target-hit events
`timescale 1ns/1ps
`default_nettype none
module peq_pipe_qualifier (
  peq_pipe_if.qual pipe
);
  genvar p;
  generate
    for (p = 0; p < peq_pkg::NUM_PIPES; p++) begin : g_pipe
      // RL13 one per string
      assign pipe.insn_q[p] = pipe.exec[p] & ~pipe.rep_iter[p];
      // RL6 executed not predicted
      assign pipe.br_q[p] = pipe.br_exec[p] & pipe.exec[p];
      // RL7 executed hits only
      assign pipe.hit_q[p] = pipe.tgt_hit[p] & pipe.exec[p];
      // RL8 taken or hit
      assign pipe.or_q[p] = (pipe.br_q[p] & pipe.br_taken[p]) | pipe.hit_q[p];
    end
  endgenerate
endmodule : peq_pipe_qualifier
`default_nettype wire

//--- rtl/peq_qualifier.sv
// performance event qualifier for codes 0fh to 19h
// Summary of operation
// RL1: count every segment and descriptor register write
// RL2: explicit loads, far transfers, task switches count
// RL3: privilege change on far transfer adds two
// RL4: count taken and not-taken executed branches
// RL5: serializing, checks, interrupts count as taken
// RL6: executed branches only; no flush implied
// RL7: target buffer hits on executed instructions
// RL8: taken branch OR target buffer hit
// RL9: count pipeline flushes from listed causes
// RL10: serializing and software interrupts never flush
// RL11: executed instructions, up to two per clock; the code counts three when a handler entry meets two executed instructions
// RL12: handler invocations and interrupts count once
// RL13: repeated string instruction counts once
// RL14: halt counts once however long halted
// RL15: second pipe executed instructions only
// RL16: bus busy clocks including hold and backoff
// RL17: store queue full stall clocks, not I/O
// RL18: codes 10h and 11h add nothing
// RL19: occurrences add count, durations add one
`timescale 1ns/1ps
`default_nettype none
module peq_qualifier #(
  parameter int INC_W = 2
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // event code
  input wire logic [peq_pkg::SEL_W-1:0] i_event_sel,
  // segment loads
  input wire logic i_seg_explicit,
  input wire logic i_seg_far_xfer,
  input wire logic i_seg_task_switch,
  input wire logic i_seg_int_far,
  input wire logic i_seg_table_write,
  input wire logic i_seg_priv_change,
  // per-pipe instruction and branch sources
  input wire logic [1:0] i_insn_exec,
  input wire logic [1:0] i_insn_rep_iter,
  input wire logic [1:0] i_br_exec,
  input wire logic [1:0] i_br_taken,
  input wire logic [1:0] i_tgt_hit,
  // other taken-branch and handler sources
  input wire logic i_serialize,
  input wire logic i_seg_check,
  input wire logic i_desc_load_br,
  input wire logic i_hw_int,
  input wire logic i_trap_fault,
  input wire logic i_handler_entry,
  // pipeline flush causes
  input wire logic [peq_pkg::FL_W-1:0] i_flush_cause,
  // bus activity, pins outside the clock domain
  input wire logic i_bus_cycle_pin,
  input wire logic i_hold_ack_pin,
  input wire logic i_addr_hold_pin,
  input wire logic i_bus_backoff_pin,
  // store queue stall
  input wire logic i_stq_full_stall,
  input wire logic i_stq_stall_io,
  // to the counter
  output logic [INC_W-1:0] o_count_inc,
  output logic o_sel_reserved,
  output logic o_sel_duration
);
  if (INC_W < 2) begin : g_bad_inc_w
    $error("INC_W must be at least 2");
  end

  peq_pipe_if pipe ();

  peq_pipe_qualifier u_pipe (
    .pipe(pipe.qual)
  );

  assign pipe.exec = i_insn_exec;
  assign pipe.rep_iter = i_insn_rep_iter;
  assign pipe.br_exec = i_br_exec;
  assign pipe.br_taken = i_br_taken;
  assign pipe.tgt_hit = i_tgt_hit;

  // bus pins are asynchronous: two stages before use
  logic [3:0] bus_s1_q;
  logic [3:0] bus_s2_q;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      bus_s1_q <= 4'h0;
      bus_s2_q <= 4'h0;
    end else begin
      bus_s1_q <= {i_bus_cycle_pin, i_hold_ack_pin, i_addr_hold_pin,
                   i_bus_backoff_pin};
      bus_s2_q <= bus_s1_q;
    end
  end

  // RL1 any segment write
  wire seg_any = i_seg_explicit | i_seg_far_xfer | i_seg_task_switch
               | i_seg_int_far | i_seg_table_write;
  // RL3 second increment
  wire seg_twice = i_seg_priv_change
                 & (i_seg_far_xfer | i_seg_task_switch | i_seg_int_far);
  // RL2 all load kinds
  wire [1:0] selector_load_event = {1'b0, seg_any} + {1'b0, seg_twice};

  // RL5 counted as taken
  wire extra_taken = i_serialize | i_seg_check | i_desc_load_br
                   | i_hw_int | i_trap_fault;
  // RL4 taken and not taken
  wire [1:0] branch_event = peq_pkg::peq_sat_add(peq_pkg::peq_pop2(pipe.br_q),
                                                 extra_taken);
  wire [1:0] branch_target_hit_event = peq_pkg::peq_pop2(pipe.hit_q);
  // RL8 logical or
  wire [1:0] branch_or_target_hit_event =
    peq_pkg::peq_sat_add(peq_pkg::peq_pop2(pipe.or_q), extra_taken);

  // RL9 listed causes counted
  // RL10 excluded causes masked
  wire flush_event = |(i_flush_cause & peq_pkg::FL_COUNT_MASK);

  // RL11 up to two pipes
  // RL14 halt is one pulse
  // RL12 handler counts as one
  wire [1:0] insn_event = peq_pkg::peq_sat_add(peq_pkg::peq_pop2(pipe.insn_q),
                                               i_handler_entry);
  // RL15 second pipe only
  wire insn_v_event = pipe.insn_q[peq_pkg::PIPE_V];

  // RL16 any bus busy clock
  wire bus_busy_clock_event = |bus_s2_q;
  // RL17 io stalls excluded
  wire store_queue_stall_event = i_stq_full_stall & ~i_stq_stall_io;

  peq_pkg::peq_class_t sel_class;
  assign sel_class = peq_pkg::peq_class(i_event_sel);

  // RL18 reserved adds zero
  wire [1:0] inc_sel =
    (i_event_sel == peq_pkg::EVT_SEG_LOAD) ? selector_load_event :
    (i_event_sel == peq_pkg::EVT_BRANCH) ? branch_event :
    (i_event_sel == peq_pkg::EVT_TGT_HIT) ? branch_target_hit_event :
    (i_event_sel == peq_pkg::EVT_BR_OR_HIT) ? branch_or_target_hit_event :
    (i_event_sel == peq_pkg::EVT_FLUSH) ? {1'b0, flush_event} :
    (i_event_sel == peq_pkg::EVT_INSN) ? insn_event :
    (i_event_sel == peq_pkg::EVT_INSN_V) ? {1'b0, insn_v_event} :
    (i_event_sel == peq_pkg::EVT_BUS) ? {1'b0, bus_busy_clock_event} :
    (i_event_sel == peq_pkg::EVT_STQ) ? {1'b0, store_queue_stall_event} :
    peq_pkg::INC_ZERO;

  // RL19 occurrences and durations
  wire [INC_W-1:0] count_inc_d = INC_W'(inc_sel);
  wire sel_reserved_d = (i_event_sel == peq_pkg::EVT_RSVD_A)
                      | (i_event_sel == peq_pkg::EVT_RSVD_B);
  wire sel_duration_d = (sel_class == peq_pkg::PEQ_CLS_DURATION);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_count_inc <= '0;
      o_sel_reserved <= 1'b0;
      o_sel_duration <= 1'b0;
    end else begin
      o_count_inc <= count_inc_d;
      o_sel_reserved <= sel_reserved_d;
      o_sel_duration <= sel_duration_d;
    end
  end

  // checks: the increment lags its sources by one clock, the bus pins by three
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  wire no_seg = ~seg_any;
  wire no_extra = ~extra_taken;

  sequence s_rep_loop;
    (i_event_sel == peq_pkg::EVT_INSN && i_insn_exec == 2'h1
     && i_insn_rep_iter == 2'h1 && !i_handler_entry)[*3];
  endsequence

  sequence s_halted;
    (i_event_sel == peq_pkg::EVT_INSN && i_insn_exec == 2'h0
     && !i_handler_entry)[*4];
  endsequence

  sequence s_backoff_held;
    (i_event_sel == peq_pkg::EVT_BUS && i_bus_backoff_pin)[*3];
  endsequence

  sequence s_hold_held;
    (i_event_sel == peq_pkg::EVT_BUS && (i_hold_ack_pin || i_addr_hold_pin))[*3];
  endsequence

  sequence s_bus_idle;
    (i_event_sel == peq_pkg::EVT_BUS && !i_bus_cycle_pin && !i_hold_ack_pin
     && !i_addr_hold_pin && !i_bus_backoff_pin)[*3];
  endsequence

  AST_SEG_TABLE: assert property ( // RL1
    i_event_sel == peq_pkg::EVT_SEG_LOAD && i_seg_table_write
    && !i_seg_priv_change |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("descriptor table write not counted once");

  AST_SEG_KINDS: assert property ( // RL2
    i_event_sel == peq_pkg::EVT_SEG_LOAD && !i_seg_priv_change
    && (i_seg_explicit || i_seg_int_far)
    |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("segment load kind not counted");

  AST_SEG_PRIV: assert property ( // RL3
    i_event_sel == peq_pkg::EVT_SEG_LOAD && i_seg_far_xfer
    && i_seg_priv_change |=> o_count_inc == INC_W'(peq_pkg::INC_TWO))
    else $error("privilege change not counted twice");

  AST_BR_NOT_TAKEN: assert property ( // RL4
    i_event_sel == peq_pkg::EVT_BRANCH && no_extra
    && i_br_exec == 2'h3 && i_insn_exec == 2'h3 && i_br_taken == 2'h0
    |=> o_count_inc == INC_W'(peq_pkg::INC_TWO))
    else $error("not-taken branches missed");

  AST_BR_EXTRA: assert property ( // RL5
    i_event_sel == peq_pkg::EVT_BRANCH && i_br_exec == 2'h0
    && (i_hw_int || i_seg_check)
    |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("implicit taken branch missed");

  AST_BR_PREDICTED: assert property ( // RL6
    i_event_sel == peq_pkg::EVT_BRANCH && no_extra
    && i_insn_exec == 2'h0 |=> o_count_inc == '0)
    else $error("unexecuted branch counted");

  AST_HIT_EXEC: assert property ( // RL7
    i_event_sel == peq_pkg::EVT_TGT_HIT && i_tgt_hit == 2'h3
    |=> o_count_inc == INC_W'(peq_pkg::peq_pop2($past(i_insn_exec))))
    else $error("target hit count wrong");

  AST_OR_HIT: assert property ( // RL8
    i_event_sel == peq_pkg::EVT_BR_OR_HIT && no_extra
    && i_insn_exec == 2'h3 && i_br_exec == 2'h1 && i_br_taken == 2'h1
    && i_tgt_hit == 2'h2 |=> o_count_inc == INC_W'(peq_pkg::INC_TWO))
    else $error("taken-or-hit not counted per pipe");

  AST_FLUSH_CAUSE: assert property ( // RL9
    i_event_sel == peq_pkg::EVT_FLUSH
    && (i_flush_cause[peq_pkg::FL_MISPRED] || i_flush_cause[peq_pkg::FL_DESC])
    |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("pipeline flush missed");

  AST_FLUSH_EXCL: assert property ( // RL10
    i_event_sel == peq_pkg::EVT_FLUSH
    && (i_flush_cause & peq_pkg::FL_COUNT_MASK) == '0 |=> o_count_inc == '0)
    else $error("excluded flush cause counted");

  AST_INSN_TWO: assert property ( // RL11
    i_event_sel == peq_pkg::EVT_INSN && i_insn_exec == 2'h3
    && i_insn_rep_iter == 2'h0 |=> o_count_inc >= INC_W'(peq_pkg::INC_TWO))
    else $error("paired instructions not counted");

  AST_INSN_HANDLER: assert property ( // RL12
    i_event_sel == peq_pkg::EVT_INSN && i_handler_entry
    && i_insn_exec == 2'h0 |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("handler entry not counted");

  AST_REP_ONCE: assert property ( // RL13
    s_rep_loop |=> o_count_inc == '0 && $past(o_count_inc) == '0)
    else $error("repeat iteration counted");

  AST_HALT_ONCE: assert property ( // RL14
    s_halted |=> o_count_inc == '0 [*1])
    else $error("halted clocks counted");

  AST_V_PIPE: assert property ( // RL15
    i_event_sel == peq_pkg::EVT_INSN_V && i_insn_rep_iter == 2'h0
    |=> o_count_inc == INC_W'({1'b0, $past(i_insn_exec[peq_pkg::PIPE_V])}))
    else $error("second pipe count wrong");

  AST_BUS_BACKOFF: assert property ( // RL16
    s_backoff_held |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("backoff clock not counted");

  AST_STQ_IO: assert property ( // RL17
    i_event_sel == peq_pkg::EVT_STQ && i_stq_full_stall
    |=> o_count_inc == INC_W'({1'b0, !$past(i_stq_stall_io)}))
    else $error("store queue stall count wrong");

  AST_RESERVED: assert property ( // RL18
    (i_event_sel == peq_pkg::EVT_RSVD_A || i_event_sel == peq_pkg::EVT_RSVD_B)
    |=> o_count_inc == '0 && o_sel_reserved)
    else $error("reserved code changed counter");

  AST_DURATION: assert property ( // RL19
    (i_event_sel == peq_pkg::EVT_BUS || i_event_sel == peq_pkg::EVT_STQ)
    |=> o_sel_duration && o_count_inc <= INC_W'(peq_pkg::INC_ONE))
    else $error("duration event above one per clock");

  AST_SEG_NONE: assert property ( // RL19
    i_event_sel == peq_pkg::EVT_SEG_LOAD && no_seg
    |=> o_count_inc == '0 && !o_sel_duration)
    else $error("segment count without a load");

  AST_BR_TAKEN: assert property ( // RL4
    i_event_sel == peq_pkg::EVT_BRANCH && no_extra
    && i_br_exec == 2'h3 && i_insn_exec == 2'h3 && i_br_taken == 2'h3
    |=> o_count_inc == INC_W'(peq_pkg::INC_TWO))
    else $error("taken branches missed");

  AST_BR_NO_FLUSH: assert property ( // RL6
    i_event_sel == peq_pkg::EVT_BRANCH && no_extra && i_insn_exec == 2'h1
    && i_br_exec[peq_pkg::PIPE_U] && i_flush_cause == '0
    |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("branch without flush not counted");

  AST_TGT_NONE: assert property ( // RL7
    i_event_sel == peq_pkg::EVT_TGT_HIT && i_tgt_hit == 2'h0 |=> o_count_inc == '0)
    else $error("target hit counted without a hit");

  AST_OR_EXTRA: assert property ( // RL8
    i_event_sel == peq_pkg::EVT_BR_OR_HIT && i_trap_fault
    && i_br_exec == 2'h0 && i_tgt_hit == 2'h0
    |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("implicit taken branch missed in taken-or-hit");

  AST_FLUSH_OTHER: assert property ( // RL9
    i_event_sel == peq_pkg::EVT_FLUSH
    && (i_flush_cause[peq_pkg::FL_BTB_MISS] || i_flush_cause[peq_pkg::FL_EXCEPT]
        || i_flush_cause[peq_pkg::FL_INTR])
    |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("flush cause missed");

  AST_INSN_NONE: assert property ( // RL11
    i_event_sel == peq_pkg::EVT_INSN && i_insn_exec == 2'h0 && !i_handler_entry
    |=> o_count_inc == '0)
    else $error("instruction counted without execution");

  AST_V_PIPE_U_ONLY: assert property ( // RL15
    i_event_sel == peq_pkg::EVT_INSN_V && i_insn_exec == 2'h1 |=> o_count_inc == '0)
    else $error("first pipe counted as second");

  AST_BUS_HOLD: assert property ( // RL16
    s_hold_held |=> o_count_inc == INC_W'(peq_pkg::INC_ONE))
    else $error("hold clock not counted");

  AST_BUS_IDLE: assert property ( // RL16
    s_bus_idle |=> o_count_inc == '0)
    else $error("idle bus clock counted");

  AST_STQ_IDLE: assert property ( // RL17
    i_event_sel == peq_pkg::EVT_STQ && !i_stq_full_stall |=> o_count_inc == '0)
    else $error("store queue counted without a stall");

  AST_UNLISTED: assert property ( // RL18
    (i_event_sel < peq_pkg::EVT_SEG_LOAD || i_event_sel > peq_pkg::EVT_STQ)
    |=> o_count_inc == '0 && !o_sel_reserved && !o_sel_duration)
    else $error("unlisted code changed counter");
endmodule : peq_qualifier
`default_nettype wire

//--- tb/peq_src_model.sv
// event source model: pipeline, bus unit and store queue occurrences
`timescale 1ns/1ps
`default_nettype none
module peq_src_model (
  // stimulus word from the bench
  input wire logic [39:0] i_stim,
  // segment, pipe and handler sources
  output logic [5:0] o_seg,
  output logic [9:0] o_pipe,
  output logic [5:0] o_extra,
  output logic [6:0] o_flush,
  // bus pins
  output logic [3:0] o_bus_pin,
  // store queue
  output logic [1:0] o_stq
);
  assign o_seg = i_stim[5:0];
  assign o_pipe = i_stim[15:6];
  assign o_extra = i_stim[21:16];
  assign o_flush = i_stim[28:22];
  // the bus unit is not edge aligned, so its pins move a little after the clock
  assign #7 o_bus_pin = i_stim[32:29];
  assign o_stq = i_stim[34:33];
endmodule : peq_src_model
`default_nettype wire

//--- tb/test_perf_event_qualifier.sv
// self-checking bench for the event qualifier
`timescale 1ns/1ps
`default_nettype none
module test_perf_event_qualifier;
  logic i_ref_clk;
  logic i_rst;
  logic [5:0] sel_q;
  logic [39:0] stim_q;
  logic bus1;
  logic bus2;
  logic [31:0] seed;
  int n_errors;
  int tests_run;
  logic [5:0] seg;
  logic [9:0] pipe;
  logic [5:0] extra;
  logic [6:0] flush;
  logic [3:0] bp;
  logic [1:0] stq;
  logic [1:0] o_count_inc;
  logic o_sel_reserved;
  logic o_sel_duration;

  peq_src_model u_peq_src_model (.i_stim(stim_q), .o_seg(seg), .o_pipe(pipe),
    .o_extra(extra), .o_flush(flush), .o_bus_pin(bp), .o_stq(stq));

  peq_qualifier u_peq_qualifier (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_event_sel(sel_q),
    .i_seg_explicit(seg[0]), .i_seg_far_xfer(seg[1]), .i_seg_task_switch(seg[2]),
    .i_seg_int_far(seg[3]), .i_seg_table_write(seg[4]), .i_seg_priv_change(seg[5]),
    .i_insn_exec(pipe[1:0]), .i_insn_rep_iter(pipe[3:2]), .i_br_exec(pipe[5:4]),
    .i_br_taken(pipe[7:6]), .i_tgt_hit(pipe[9:8]), .i_serialize(extra[0]),
    .i_seg_check(extra[1]), .i_desc_load_br(extra[2]), .i_hw_int(extra[3]),
    .i_trap_fault(extra[4]), .i_handler_entry(extra[5]), .i_flush_cause(flush),
    .i_bus_cycle_pin(bp[0]), .i_hold_ack_pin(bp[1]), .i_addr_hold_pin(bp[2]),
    .i_bus_backoff_pin(bp[3]), .i_stq_full_stall(stq[0]), .i_stq_stall_io(stq[1]),
    .o_count_inc(o_count_inc), .o_sel_reserved(o_sel_reserved),
    .o_sel_duration(o_sel_duration));

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [1:0] exp_inc(input logic [5:0] sel, input logic [39:0] s,
                                         input logic bus);
    logic [1:0] ex;
    logic xt;
    int n;
    ex = s[7:6];
    xt = |s[20:16];
    case (sel)
      6'h0f: n = (|s[4:0]) + (s[5] & |s[3:1]);
      6'h12: n = $countones(ex & s[11:10]) + xt;
      6'h13: n = $countones(ex & s[15:14]);
      6'h14: n = $countones(ex & (s[11:10] & s[13:12] | s[15:14])) + xt;
      6'h15: n = |s[26:22];
      6'h16: n = $countones(ex & ~s[9:8]) + s[21];
      6'h17: n = s[7] & ~s[9];
      6'h18: n = bus;
      6'h19: n = s[33] & ~s[34];
      default: n = 0;
    endcase
    return (n > 3) ? 2'h3 : 2'(n);
  endfunction : exp_inc

  task automatic chk_inc(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: increment %h expected %h", $time, got, exp);
    end
  endtask : chk_inc

  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask : chk_flag

  // bus pins reach the output two clocks later than the other sources
  task automatic step(input logic [5:0] sel, input logic [39:0] s, input logic rst = 1'b0);
    logic [1:0] e;
    logic er;
    logic ed;
    @(posedge i_ref_clk);
    e = i_rst ? 2'h0 : exp_inc(sel_q, stim_q, bus2);
    er = !i_rst && (sel_q == 6'h10 || sel_q == 6'h11);
    ed = !i_rst && (sel_q == 6'h18 || sel_q == 6'h19);
    bus2 = i_rst ? 1'b0 : bus1;
    bus1 = i_rst ? 1'b0 : |stim_q[32:29];
    sel_q <= sel;
    stim_q <= s;
    i_rst <= rst;
    @(negedge i_ref_clk);
    chk_inc(o_count_inc, e);
    chk_flag(o_sel_reserved, er);
    chk_flag(o_sel_duration, ed);
  endtask : step

  task automatic done(input string name);
    $display("test %s ended: %0d checks, %0d mismatches", name, tests_run, n_errors);
  endtask : done

  task automatic conclude();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    #250000;
    n_errors++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    i_rst = 1'b1;
    sel_q = 6'h00;
    stim_q = 40'h0;
    bus1 = 1'b0;
    bus2 = 1'b0;
    seed = 32'hed7e;
    n_errors = 0;
    tests_run = 0;
    repeat (9) step(6'h00, 40'h0, 1'b1);
    step(6'h16, 40'hc0);
    step(6'h16, 40'h2000c0);
    step(6'h16, 40'h40);
    repeat (4) step(6'h16, 40'h140);
    step(6'h16, 40'h40);
    repeat (5) step(6'h16, 40'h0);
    step(6'h17, 40'hc0);
    step(6'h17, 40'h2c0);
    done("instructions");
    step(6'h0f, 40'h22);
    step(6'h0f, 40'h2c);
    step(6'h0f, 40'h10);
    step(6'h0f, 40'h21);
    step(6'h0f, 40'h08);
    done("segment loads");
    step(6'h12, 40'hc40);
    step(6'h12, 40'h3cc0);
    step(6'h12, 40'h10000);
    step(6'h12, 40'h1f0cc0);
    step(6'h12, 40'hc00);
    step(6'h13, 40'h4000);
    step(6'h13, 40'hc0c0);
    step(6'h14, 40'h1440);
    step(6'h14, 40'h8080);
    step(6'h14, 40'h100000);
    done("branches");
    for (int i = 0; i < 7; i++) step(6'h15, 40'h1 << (22 + i));
    step(6'h10, 40'hff_ffff_ffff);
    step(6'h11, 40'hff_ffff_ffff);
    for (int j = 0; j < 4; j++) repeat (3) step(6'h18, 40'h1 << (29 + j));
    repeat (3) step(6'h18, 40'h0);
    step(6'h19, 40'h2_0000_0000);
    step(6'h19, 40'h6_0000_0000);
    done("flush, reserved, durations");
    repeat (3) step(6'h00, 40'h0, 1'b1);
    for (int k = 0; k < 3000; k++) begin
      r = xs();
      step(6'h0e + 6'(r % 13), {5'h0, r[31:29], xs() & xs()});
    end
    done("random");
    conclude();
  end
endmodule : test_perf_event_qualifier
`default_nettype wire
